// file: inc/port_b_map.vh
// Purpose: constants for the port b pin block
// Assumes: 8-bit port, change detect on upper four pins
// Notes: reset values apply on power-on reset only
`ifndef PORT_B_MAP_VH
`define PORT_B_MAP_VH

// =============================================================
// widths
`define PORT_WIDTH 8
`define CHANGE_LO 4
`define CHANGE_HI 7
`define ANALOG_PINS 6

// =============================================================
// power-on reset values and analog strap choices
`define DIRECTION_RESET 8'hff
`define LATCH_RESET 8'h00
`define PULLUP_EN_RESET 8'h00
`define PULLUP_GLOBAL_DISABLE_RESET 1'b1
`define CHANGE_EN_RESET 4'h0
`define ANALOG_ALL 6'h3f
`define ANALOG_NONE 6'h00

`endif

// file: logic/pin_sync.v
// Purpose: two flip-flop synchroniser for the port pins
// Assumes: pins are asynchronous to clock
// Notes: first stage read only by second stage
`include "port_b_map.vh"

module pin_sync (
    input wire clock,
    input wire resetn,
    input wire [`PORT_WIDTH-1:0] pin_async,
    output reg [`PORT_WIDTH-1:0] pin_synced
);

// =============================================================
// two stages
reg [`PORT_WIDTH-1:0] stage_one;

always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        stage_one <= 8'h00;
        pin_synced <= 8'h00;
    end else begin
        stage_one <= pin_async;
        pin_synced <= stage_one;
    end
end

endmodule

// file: logic/output_priority_mux.v
// Purpose: per-pin output priority selection
// Assumes: peripheral enables are active high
// Notes: analog select does not block digital outputs
`include "port_b_map.vh"

module output_priority_mux (
    input wire [`PORT_WIDTH-1:0] port_output_latch,
    input wire [`PORT_WIDTH-1:0] port_direction,
    input wire sda_en,
    input wire sda_out,
    input wire scl_en,
    input wire scl_out,
    input wire sck_en,
    input wire sck_out,
    input wire pwm_output_c_en,
    input wire pwm_output_c,
    input wire pwm_output_b_en,
    input wire pwm_output_b,
    input wire spi_data_out_en,
    input wire spi_data_out,
    input wire capture_compare_two_en,
    input wire capture_compare_two,
    input wire pwm_output_d_en,
    input wire pwm_output_d,
    input wire program_clock_en,
    input wire program_clock,
    input wire program_data_en,
    input wire program_data,
    input wire debug_alt_clock_en,
    input wire debug_alt_clock,
    input wire debug_alt_data_en,
    input wire debug_alt_data,
    output reg [`PORT_WIDTH-1:0] pin_out,
    output reg [`PORT_WIDTH-1:0] pin_oe
);

// =============================================================
// priority chains, highest first
always @* begin
    pin_out = port_output_latch;
    pin_oe = ~port_direction;
    // bit 0
    if (sda_en) begin
        pin_out[0] = sda_out;
        pin_oe[0] = 1'b1;
    end
    // bit 1
    if (scl_en) begin
        pin_out[1] = scl_out;
        pin_oe[1] = 1'b1;
    end else if (sck_en) begin
        pin_out[1] = sck_out;
        pin_oe[1] = 1'b1;
    end else if (pwm_output_c_en) begin
        pin_out[1] = pwm_output_c;
        pin_oe[1] = 1'b1;
    end
    // bit 2
    if (pwm_output_b_en) begin
        pin_out[2] = pwm_output_b;
        pin_oe[2] = 1'b1;
    end
    // bit 3
    if (spi_data_out_en) begin
        pin_out[3] = spi_data_out;
        pin_oe[3] = 1'b1;
    end else if (capture_compare_two_en) begin
        pin_out[3] = capture_compare_two;
        pin_oe[3] = 1'b1;
    end
    // bit 4
    if (pwm_output_d_en) begin
        pin_out[4] = pwm_output_d;
        pin_oe[4] = 1'b1;
    end
    // bit 6
    if (program_clock_en) begin
        pin_out[6] = program_clock;
        pin_oe[6] = 1'b1;
    end else if (debug_alt_clock_en) begin
        pin_out[6] = debug_alt_clock;
        pin_oe[6] = 1'b1;
    end
    // bit 7
    if (program_data_en) begin
        pin_out[7] = program_data;
        pin_oe[7] = 1'b1;
    end else if (debug_alt_data_en) begin
        pin_out[7] = debug_alt_data;
        pin_oe[7] = 1'b1;
    end
end

endmodule

// file: logic/port_b_pullup_change_irq.v
// Purpose: 8-bit general purpose port with pull-ups and change detect
// Assumes: register strobes come from logic on the same clock
// Notes: last-read latch survives warm resets
`include "port_b_map.vh"

module port_b_pullup_change_irq (
    input wire clock,
    input wire resetn,
    input wire warm_resetn,
    input wire analog_default_select,
    input wire [7:0] pin_in,
    output wire [7:0] pin_out,
    output wire [7:0] pin_oe,
    output reg [7:0] pullup_on,
    input wire [7:0] write_data,
    input wire port_pin_read_rd,
    input wire port_pin_read_wr,
    input wire memory_to_memory_move,
    input wire port_output_latch_wr,
    input wire port_direction_wr,
    input wire pullup_enable_bits_wr,
    input wire pullup_global_disable_wr,
    input wire change_enable_bits_wr,
    input wire change_irq_global_enable_wr,
    input wire analog_select_bits_wr,
    input wire change_irq_flag_clear,
    output reg [7:0] port_pin_read,
    output reg [7:0] port_output_latch,
    output reg [7:0] port_direction,
    output reg [7:0] pullup_enable_bits,
    output reg pullup_global_disable,
    output reg [3:0] change_enable_bits,
    output reg change_irq_global_enable,
    output reg [5:0] analog_select_bits,
    output reg change_irq_flag,
    output reg change_wake,
    input wire sda_en,
    input wire sda_out,
    input wire scl_en,
    input wire scl_out,
    input wire sck_en,
    input wire sck_out,
    input wire pwm_output_c_en,
    input wire pwm_output_c,
    input wire pwm_output_b_en,
    input wire pwm_output_b,
    input wire spi_data_out_en,
    input wire spi_data_out,
    input wire capture_compare_two_en,
    input wire capture_compare_two,
    input wire pwm_output_d_en,
    input wire pwm_output_d,
    input wire program_clock_en,
    input wire program_clock,
    input wire program_data_en,
    input wire program_data,
    input wire debug_alt_clock_en,
    input wire debug_alt_clock,
    input wire debug_alt_data_en,
    input wire debug_alt_data
);

// =============================================================
// pin synchronisation
wire [7:0] pin_synced;

pin_sync sync_inst (
    .clock(clock),
    .resetn(resetn),
    .pin_async(pin_in),
    .pin_synced(pin_synced)
);

// =============================================================
// output multiplexer
output_priority_mux mux_inst (
    .port_output_latch(port_output_latch),
    .port_direction(port_direction),
    .sda_en(sda_en),
    .sda_out(sda_out),
    .scl_en(scl_en),
    .scl_out(scl_out),
    .sck_en(sck_en),
    .sck_out(sck_out),
    .pwm_output_c_en(pwm_output_c_en),
    .pwm_output_c(pwm_output_c),
    .pwm_output_b_en(pwm_output_b_en),
    .pwm_output_b(pwm_output_b),
    .spi_data_out_en(spi_data_out_en),
    .spi_data_out(spi_data_out),
    .capture_compare_two_en(capture_compare_two_en),
    .capture_compare_two(capture_compare_two),
    .pwm_output_d_en(pwm_output_d_en),
    .pwm_output_d(pwm_output_d),
    .program_clock_en(program_clock_en),
    .program_clock(program_clock),
    .program_data_en(program_data_en),
    .program_data(program_data),
    .debug_alt_clock_en(debug_alt_clock_en),
    .debug_alt_clock(debug_alt_clock),
    .debug_alt_data_en(debug_alt_data_en),
    .debug_alt_data(debug_alt_data),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
);

// =============================================================
// configuration registers, power-on reset
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        port_direction <= `DIRECTION_RESET;
        pullup_enable_bits <= `PULLUP_EN_RESET;
        pullup_global_disable <= `PULLUP_GLOBAL_DISABLE_RESET;
        change_enable_bits <= `CHANGE_EN_RESET;
        change_irq_global_enable <= 1'b0;
        port_output_latch <= `LATCH_RESET;
    end else begin
        if (port_direction_wr)
            port_direction <= write_data;
        if (port_output_latch_wr || port_pin_read_wr)
            port_output_latch <= write_data;
        if (pullup_enable_bits_wr)
            pullup_enable_bits <= write_data;
        if (pullup_global_disable_wr)
            pullup_global_disable <= write_data[0];
        if (change_enable_bits_wr)
            change_enable_bits <= write_data[`CHANGE_HI:`CHANGE_LO];
        if (change_irq_global_enable_wr)
            change_irq_global_enable <= write_data[0];
    end
end

// =============================================================
// analog default caught after reset release
reg strap_taken;

always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        strap_taken <= 1'b0;
        analog_select_bits <= `ANALOG_ALL;
    end else if (!strap_taken) begin
        strap_taken <= 1'b1;
        analog_select_bits <= analog_default_select ? `ANALOG_ALL : `ANALOG_NONE;
    end else if (analog_select_bits_wr) begin
        analog_select_bits <= write_data[5:0];
    end
end

// =============================================================
// pin read data, analog pins read zero
always @(posedge clock or negedge resetn) begin
    if (!resetn)
        port_pin_read <= 8'h00;
    else
        port_pin_read <= pin_synced & ~{2'b00, analog_select_bits};
end

// =============================================================
// weak pull-ups
always @(posedge clock or negedge resetn) begin
    if (!resetn)
        pullup_on <= 8'h00;
    else
        pullup_on <= pullup_enable_bits & port_direction
            & {8{~pullup_global_disable}};
end

// =============================================================
// change detection, latch kept through warm reset
reg [3:0] last_read;
wire port_access;
wire [3:0] mismatch;
wire change_hit;

assign port_access = (port_pin_read_rd || port_pin_read_wr)
    && !memory_to_memory_move;
assign mismatch = (pin_synced[`CHANGE_HI:`CHANGE_LO] ^ last_read)
    & change_enable_bits & port_direction[`CHANGE_HI:`CHANGE_LO];
assign change_hit = |mismatch;

always @(posedge clock or negedge resetn) begin
    if (!resetn)
        last_read <= 4'h0;
    else if (port_access)
        last_read <= pin_synced[`CHANGE_HI:`CHANGE_LO];
end

always @(posedge clock or negedge warm_resetn) begin
    if (!warm_resetn) begin
        change_irq_flag <= 1'b0;
        change_wake <= 1'b0;
    end else begin
        if (change_hit && !port_access)
            change_irq_flag <= 1'b1;
        else if (change_irq_flag_clear)
            change_irq_flag <= 1'b0;
        change_wake <= change_irq_flag && change_irq_global_enable;
    end
end

endmodule

// file: tb/port_b_checker.sv
// Purpose: concurrent checks on the port b pin block
// Assumes: one clock domain, resetn async active low
// Notes: bound to every instance of the block
module port_b_checker (
    input wire clock, resetn, warm_resetn, sda_en, sda_out,
    input wire port_pin_read_wr, port_output_latch_wr, change_irq_flag_clear,
    input wire pullup_global_disable, change_irq_global_enable, change_irq_flag, change_wake,
    input wire [7:0] pin_in, pin_out, pin_oe, pullup_on, write_data, port_pin_read,
    input wire [7:0] port_output_latch, port_direction, pullup_enable_bits,
    input wire [3:0] change_enable_bits,
    input wire [5:0] analog_select_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // ==========================================
    // helper: pull-up value one sample back
    logic [7:0] pu_prev;
    wire [7:0] pu_exp = pullup_enable_bits & port_direction & {8{!pullup_global_disable}};
    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            pu_prev <= 8'h00;
        else
            pu_prev <= pu_exp;
    end
    sequence s_flag_kept;
        change_irq_flag && !change_irq_flag_clear ##1 warm_resetn;
    endsequence
    sequence s_latch_write;
        port_output_latch_wr || port_pin_read_wr;
    endsequence
    // ==========================================
    // assertions
    a_dir_drives_latch: assert property (
        !port_direction[5] |-> pin_oe[5] && pin_out[5] == port_output_latch[5])
        else $error("latch-only pin not driven");
    a_prio_sda_wins: assert property (
        sda_en && !port_direction[0] |-> pin_out[0] == sda_out) else $error("bit0 priority");
    a_pullup_gate: assert property (
        pu_exp == pu_prev |-> pullup_on == pu_exp) else $error("pull-up value wrong");
    a_pullup_reset: assert property (
        !$past(resetn) |-> pullup_on == 8'h00) else $error("pull-up on after reset");
    a_latch_write: assert property (
        s_latch_write |=> port_output_latch == $past(write_data)) else $error("latch write");
    a_wake_gated: assert property (
        change_wake |-> change_irq_global_enable || $past(change_irq_global_enable))
        else $error("wake without enable");
    a_flag_cause: assert property (
        $rose(change_irq_flag) |-> |(change_enable_bits & port_direction[7:4])
        || $past(|(change_enable_bits & port_direction[7:4]))) else $error("flag uncaused");
    a_flag_held: assert property (
        s_flag_kept |-> change_irq_flag) else $error("flag dropped");
    a_read_delay: assert property (
        $past(resetn, 1) && $past(resetn, 2) && $past(resetn, 3)
        |-> port_pin_read[7:6] == $past(pin_in[7:6], 3)) else $error("pin read lag");
    a_analog_zero: assert property (
        analog_select_bits[0] && $past(analog_select_bits[0]) |-> !port_pin_read[0])
        else $error("analog pin reads one");
endmodule

bind port_b_pullup_change_irq port_b_checker u_port_b_checker (.*);

// file: tb/pin_partner.sv
// Purpose: pads and outside circuitry of the port
// Assumes: device drive wins where its enable is high
// Notes: an undriven pin without pull-up toggles each cycle
module pin_partner (
    input wire clock,
    input wire [7:0] pin_out, pin_oe, pullup_on, ext_en, ext_val,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip = 1'b0;
    always @(posedge clock) begin
        flip <= !flip;
    end
    always_comb begin
        for (int i = 0; i < 8; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pullup_on[i] | flip;
    end
endmodule

// file: tb/port_b_pullup_change_irq_tb.sv
// Purpose: self-checking bench for the port b pin block
// Assumes: strobes are one-cycle pulses
// Notes: pads resolved by the partner model
module port_b_pullup_change_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, resetn = 0, warm = 1, mv = 0, strap = 1;
    logic [9:0] st = 0;
    logic [11:0] e = 0, v = 0;
    logic [7:0] write_data = 0, ext_en = 8'hFF, ext_val = 0;
    wire [7:0] pin_in, pin_out, pin_oe, pullup_on, port_pin_read, port_output_latch;
    wire [7:0] port_direction, pullup_enable_bits;
    wire [5:0] analog_select_bits;
    wire [3:0] change_enable_bits;
    wire pullup_global_disable, change_irq_global_enable, change_irq_flag, change_wake;
    int num_errors = 0, n_compared = 0;
    port_b_pullup_change_irq u_port_b_pullup_change_irq (
        .clock, .resetn, .warm_resetn(resetn & warm), .analog_default_select(strap),
        .pin_in, .pin_out, .pin_oe, .pullup_on, .write_data,
        .port_pin_read_wr(st[0]), .port_output_latch_wr(st[1]), .port_direction_wr(st[2]),
        .pullup_enable_bits_wr(st[3]), .pullup_global_disable_wr(st[4]),
        .change_enable_bits_wr(st[5]), .change_irq_global_enable_wr(st[6]),
        .analog_select_bits_wr(st[7]), .port_pin_read_rd(st[8]), .change_irq_flag_clear(st[9]),
        .memory_to_memory_move(mv), .port_pin_read, .port_output_latch, .port_direction,
        .pullup_enable_bits, .pullup_global_disable, .change_enable_bits,
        .change_irq_global_enable, .analog_select_bits, .change_irq_flag, .change_wake,
        .sda_en(e[0]), .sda_out(v[0]), .scl_en(e[1]), .scl_out(v[1]), .sck_en(e[2]),
        .sck_out(v[2]), .pwm_output_c_en(e[3]), .pwm_output_c(v[3]), .pwm_output_b_en(e[4]),
        .pwm_output_b(v[4]), .spi_data_out_en(e[5]), .spi_data_out(v[5]),
        .capture_compare_two_en(e[6]), .capture_compare_two(v[6]), .pwm_output_d_en(e[7]),
        .pwm_output_d(v[7]), .program_clock_en(e[8]), .program_clock(v[8]),
        .program_data_en(e[9]), .program_data(v[9]), .debug_alt_clock_en(e[10]),
        .debug_alt_clock(v[10]), .debug_alt_data_en(e[11]), .debug_alt_data(v[11]));
    pin_partner u_pin_partner (.clock, .pin_out, .pin_oe, .pullup_on, .ext_en, .ext_val, .pin_in);
    initial forever #12.5 clock = ~clock;
    // ==========================================
    // shared tasks
    task automatic chk(input string nm, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input int i, input logic [7:0] d);
        @(posedge clock);
        st[i] <= 1'b1;
        write_data <= d;
        @(posedge clock);
        st[i] <= 1'b0;
        #1;
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset;
        chk("direction", 8'hFF, port_direction);
        chk("pull-ups", 8'h00, pullup_on);
        chk("pull-up disable", 8'h01, pullup_global_disable);
        chk("analog", 8'h3F, analog_select_bits);
        chk("low pins", 8'h00, port_pin_read & 8'h3F);
    endtask
    task automatic t_prio;
        wr(2, 8'h00);
        e <= 12'hFFF;
        v <= 12'h3B3;
        gap(1);
        chk("first tier", 8'hDF, pin_out);
        chk("drive enables", 8'hFF, pin_oe);
        e <= 12'hC4C;
        v <= 12'hC44;
        gap(1);
        chk("second tier", 8'hCA, pin_out);
        e <= 12'h008;
        v <= 12'h000;
        wr(1, 8'hFF);
        chk("third tier", 8'hFD, pin_out);
        e <= 12'h000;
        wr(2, 8'hF0);
        wr(1, 8'hA5);
        chk("enables by direction", 8'h0F, pin_oe);
        chk("latch drive", 8'h05, pin_out & 8'h0F);
    endtask
    task automatic t_pull;
        ext_en <= 8'h00;
        wr(3, 8'hFF);
        gap(2);
        chk("pull-ups disabled", 8'h00, pullup_on);
        wr(4, 8'h00);
        gap(2);
        chk("pull-ups inputs", 8'hF0, pullup_on);
        wr(3, 8'h5A);
        gap(2);
        chk("pull-ups per pin", 8'h50, pullup_on);
        chk("pull-up enables", 8'h5A, pullup_enable_bits);
        wr(4, 8'h01);
        gap(2);
        chk("pull-ups global off", 8'h00, pullup_on);
        ext_en <= 8'hFF;
    endtask
    task automatic t_latch;
        wr(7, 8'h00);
        wr(2, 8'hFF);
        ext_val <= 8'hC3;
        wr(1, 8'h3C);
        gap(4);
        chk("latch readback", 8'h3C, port_output_latch);
        chk("pin read", 8'hC3, port_pin_read);
        wr(0, 8'h81);
        chk("port write", 8'h81, port_output_latch);
    endtask
    task automatic t_change;
        wr(2, 8'hEF);
        wr(5, 8'hD0);
        chk("change enables", 8'h0D, change_enable_bits);
        wr(6, 8'h01);
        wr(8, 8'h00);
        wr(9, 8'h00);
        gap(4);
        chk("flag idle", 8'h00, change_irq_flag);
        ext_val <= 8'hE3;
        wr(1, 8'h91);
        gap(6);
        chk("flag masked", 8'h00, change_irq_flag);
        ext_val <= 8'h63;
        gap(6);
        chk("flag", 8'h01, change_irq_flag);
        chk("wake", 8'h01, change_wake);
        wr(9, 8'h00);
        chk("flag kept", 8'h01, change_irq_flag);
        mv <= 1'b1;
        wr(8, 8'h00);
        mv <= 1'b0;
        wr(9, 8'h00);
        chk("flag after move", 8'h01, change_irq_flag);
        wr(8, 8'h00);
        gap(1);
        wr(9, 8'h00);
        chk("flag cleared", 8'h00, change_irq_flag);
        ext_val <= 8'h23;
        gap(6);
        warm <= 1'b0;
        gap(1);
        chk("flag in warm reset", 8'h00, change_irq_flag);
        warm <= 1'b1;
        gap(6);
        chk("flag after warm", 8'h01, change_irq_flag);
        wr(6, 8'h00);
        gap(2);
        chk("wake disabled", 8'h00, change_wake);
    endtask
    task automatic t_strap;
        strap <= 1'b0;
        resetn <= 1'b0;
        gap(3);
        resetn <= 1'b1;
        gap(4);
        chk("analog strap off", 8'h00, analog_select_bits);
        chk("digital low pins", 8'h23, port_pin_read);
        chk("flag after power-on", 8'h00, change_irq_flag);
    endtask
    initial begin
        #50us;
        num_errors++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        gap(2);
        t_reset;
        t_prio;
        t_pull;
        t_latch;
        t_change;
        t_strap;
        stop_test;
    end
endmodule
